// ### hw/switch_pkg.sv
package switch_pkg;

    // seven-bit target address: fixed upper bits, straps in the low three
    localparam logic [6:0] ADDR_BASE   = 7'h70;
    localparam int         STRAP_W     = 3;
    localparam int         CHAN_N      = 8;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] CNT_RST     = 4'h0;
    localparam logic [3:0] CNT_FIRST   = 4'h1;
    localparam logic [7:0] CHAN_RST    = 8'h00;
    localparam logic       RW_READ     = 1'b1;
    // upstream serial clock ceiling and the link oversampling it allows
    localparam int         SCL_MAX_KHZ = 400;
    localparam int         LINK_KHZ    = 66666;
    localparam int         OVERSAMPLE  = LINK_KHZ / SCL_MAX_KHZ;
    localparam int         OVS_MIN     = 8;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } link_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

endpackage

// ### hw/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
    parameter int         W       = 1,
    parameter logic [0:0] RST_VAL = 1'b0
) (
    // clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rst,
    // asynchronous input and synchronised output
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= {W{RST_VAL}};
            q      <= {W{RST_VAL}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ### hw/chan_switch.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01: master starts only on idle bus, SDA falling while SCL high
// RULE_02: master transfers only while no start is left without its stop
// RULE_03: address byte arrives MSB first, direction bit last; shifted in so
// RULE_04: matching address is acknowledged by holding SDA low over ack clock
// RULE_05: straps stay unchanged between start and stop
// RULE_06: one bit per SCL pulse; SDA change with SCL high is start or stop
// RULE_07: master ends each transaction with SDA rising while SCL high
// RULE_08: any number of bytes may pass between start and stop
// RULE_09: each byte is eight bits plus an acknowledge slot on pulse nine
// RULE_10: transmitter releases SDA after eighth bit for the acknowledge
// RULE_11: as receiver the device acknowledges every byte
// RULE_12: master acknowledges every read byte except the last
// RULE_13: master ends a read by leaving SDA high in final ack slot
// RULE_14: after a not-acknowledge the device releases SDA
// RULE_15: upstream pair fans out to eight independently switched pairs
// RULE_16: channel connection follows only the channel-select value
// RULE_17: power-on reset deselects all channels and resets the bus machine
// RULE_18: reset pin low does the same as power-on reset
// RULE_19: three straps give the low address bits, eight devices per bus
// RULE_20: target logic works at serial clock up to fast-mode speed
// RULE_21: address is 0x70 plus the strap value
// RULE_22: direction bit one means read, zero means write
// RULE_23: bit n of select byte enables channel n; several may be on
// RULE_24: new selection connects nothing until the next stop
// RULE_25: reads return the select byte; foreign addresses are not acknowledged
// RULE_26: last byte of a write transaction becomes the selection
module chan_switch
    import switch_pkg::*;
(
    // core clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // link sampling clock
    input  wire logic              link_clk,
    // reset pin and address straps
    input  wire logic              reset_pin_n,
    input  wire logic              addr_strap_bit0,
    input  wire logic              addr_strap_bit1,
    input  wire logic              addr_strap_bit2,
    // upstream bus
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // downstream pairs, open drain
    output logic [CHAN_N-1:0]      downstream_clock_n_out,
    output logic [CHAN_N-1:0]      downstream_clock_n_oe,
    output logic [CHAN_N-1:0]      downstream_data_n_out,
    output logic [CHAN_N-1:0]      downstream_data_n_oe,
    // selection seen by the core
    output logic [CHAN_N-1:0]      chan_sel_q
);

    bus_pins_t          pins_s;
    bus_pins_t          pins_p_q;
    logic [STRAP_W-1:0] strap_s;
    logic [1:0]         lrst_s;
    logic               link_rst;
    logic               pin_rst_core_n;
    logic               core_rst;
    link_state_t        state_q;
    logic [3:0]         cnt_q;
    logic [7:0]         shift_q;
    logic [7:0]         tx_q;
    logic [7:0]         pend_q;
    logic               pend_vld_q;
    logic [7:0]         act_q;
    logic [7:0]         hold_q;
    logic               tgl_q;
    logic               ack_seen_q;
    logic               start_c;
    logic               stop_c;
    logic               rise_c;
    logic               fall_c;
    logic               match_c;
    logic [6:0]         own_addr;
    logic               tgl_s;
    logic               tgl_p_q;
    logic               tgl_edge;

    initial begin
        if (OVERSAMPLE < OVS_MIN) begin // see RULE_20
            $error("link clock too slow for fast-mode sampling");
        end
    end

    // link side synchronisers
    bit_sync #(.W(2), .RST_VAL(1'b1)) u_pin_sync (
        .clk (link_clk),
        .rst (1'b0),
        .d   ({scl_in, sda_in}),
        .q   (pins_s)
    );

    bit_sync #(.W(STRAP_W), .RST_VAL(1'b0)) u_strap_sync (
        .clk (link_clk),
        .rst (1'b0),
        .d   ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
        .q   (strap_s)
    );

    bit_sync #(.W(2), .RST_VAL(1'b1)) u_lrst_sync (
        .clk (link_clk),
        .rst (1'b0),
        .d   ({sys_rst, ~reset_pin_n}),
        .q   (lrst_s)
    );

    assign link_rst = |lrst_s; // see RULE_18

    // core side synchronisers
    bit_sync #(.W(1), .RST_VAL(1'b0)) u_crst_sync (
        .clk (core_clk),
        .rst (sys_rst),
        .d   (reset_pin_n),
        .q   (pin_rst_core_n)
    );

    assign core_rst = sys_rst | ~pin_rst_core_n; // see RULE_17

    bit_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_sync (
        .clk (core_clk),
        .rst (core_rst),
        .d   (tgl_q),
        .q   (tgl_s)
    );

    // bus events from the synchronised pins
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            pins_p_q <= '1;
        end else begin
            pins_p_q <= pins_s;
        end
    end

    assign start_c  = pins_s.scl & pins_p_q.scl & pins_p_q.sda & ~pins_s.sda; // see RULE_06
    assign stop_c   = pins_s.scl & pins_p_q.scl & ~pins_p_q.sda & pins_s.sda; // see RULE_06
    assign rise_c   = pins_s.scl & ~pins_p_q.scl;
    assign fall_c   = ~pins_s.scl & pins_p_q.scl;
    assign own_addr = {ADDR_BASE[6:STRAP_W], strap_s}; // see RULE_19 see RULE_21
    assign match_c  = (shift_q[7:1] == own_addr);

    // target state machine, bit counter and shifters
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state_q    <= ST_IDLE; // see RULE_17
            cnt_q      <= CNT_RST;
            shift_q    <= CHAN_RST;
            tx_q       <= CHAN_RST;
            sda_oe     <= 1'b0;
            ack_seen_q <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_ADDR; // see RULE_06
            cnt_q   <= CNT_RST;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WR: begin
                    if (rise_c && cnt_q != BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], pins_s.sda}; // see RULE_03
                        cnt_q   <= cnt_q + CNT_FIRST;
                    end else if (fall_c && cnt_q == BYTE_BITS) begin // see RULE_09
                        if (state_q == ST_WR) begin
                            sda_oe  <= 1'b1; // see RULE_11
                            state_q <= ST_WR_ACK;
                        end else if (match_c) begin
                            sda_oe  <= 1'b1; // see RULE_04
                            state_q <= ST_ADDR_ACK;
                        end else begin
                            state_q <= ST_IDLE; // see RULE_25
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK, ST_RD_ACK: begin
                    if (rise_c) begin
                        ack_seen_q <= ~pins_s.sda;
                    end
                    if (fall_c) begin
                        cnt_q <= CNT_RST;
                        if (state_q == ST_RD_ACK && !ack_seen_q) begin
                            sda_oe  <= 1'b0; // see RULE_14
                            state_q <= ST_IDLE;
                        end else if (state_q == ST_WR_ACK ||
                                     (state_q == ST_ADDR_ACK && shift_q[0] != RW_READ)) begin
                            sda_oe  <= 1'b0; // see RULE_08 see RULE_22
                            state_q <= ST_WR;
                        end else begin
                            tx_q    <= act_q << 1; // see RULE_25
                            sda_oe  <= ~act_q[7];
                            cnt_q   <= CNT_FIRST;
                            state_q <= ST_RD;
                        end
                    end
                end
                ST_RD: begin
                    if (fall_c) begin
                        if (cnt_q == BYTE_BITS) begin
                            sda_oe  <= 1'b0; // see RULE_10
                            state_q <= ST_RD_ACK;
                        end else begin
                            sda_oe <= ~tx_q[7];
                            tx_q   <= tx_q << 1;
                            cnt_q  <= cnt_q + CNT_FIRST;
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // pending write byte, committed at stop
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            pend_q     <= CHAN_RST;
            pend_vld_q <= 1'b0;
            act_q      <= CHAN_RST; // see RULE_17
            hold_q     <= CHAN_RST;
            tgl_q      <= 1'b0;
        end else if (stop_c) begin
            pend_vld_q <= 1'b0;
            if (pend_vld_q) begin
                act_q  <= pend_q; // see RULE_24
                hold_q <= pend_q;
                tgl_q  <= ~tgl_q;
            end
        end else if (state_q == ST_WR && fall_c && cnt_q == BYTE_BITS) begin
            pend_q     <= shift_q; // see RULE_26
            pend_vld_q <= 1'b1;
        end
    end

    // pass gates: downstream lines follow upstream low on enabled channels
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            downstream_clock_n_oe <= '0;
            downstream_data_n_oe  <= '0;
        end else begin
            downstream_clock_n_oe <= act_q & {CHAN_N{~pins_s.scl}}; // see RULE_15 see RULE_23
            downstream_data_n_oe  <= act_q & {CHAN_N{~pins_s.sda}}; // see RULE_16
        end
    end

    always_ff @(posedge link_clk) begin
        sda_out                <= 1'b0;
        downstream_clock_n_out <= '0;
        downstream_data_n_out  <= '0;
    end

    // core copy of the selection
    always_ff @(posedge core_clk) begin
        if (core_rst) begin
            tgl_p_q <= 1'b0;
        end else begin
            tgl_p_q <= tgl_s;
        end
    end

    assign tgl_edge = tgl_s ^ tgl_p_q;

    always_ff @(posedge core_clk) begin
        if (core_rst) begin
            chan_sel_q <= CHAN_RST; // see RULE_18
        end else if (tgl_edge) begin
            chan_sel_q <= hold_q; // see RULE_16
        end
    end

    start_resets_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_06
        start_c |=> state_q == ST_ADDR && !sda_oe && cnt_q == CNT_RST)
        else $error("start did not restart address phase");

    stop_idles_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_06
        stop_c && !start_c |=> state_q == ST_IDLE && !sda_oe)
        else $error("stop did not idle the target");

    addr_ack_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_04
        !start_c && !stop_c && fall_c && state_q == ST_ADDR && cnt_q == BYTE_BITS && match_c
        |=> sda_oe && state_q == ST_ADDR_ACK)
        else $error("own address not acknowledged");

    foreign_addr_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_25
        !start_c && !stop_c && fall_c && state_q == ST_ADDR && cnt_q == BYTE_BITS && !match_c
        |=> !sda_oe && state_q == ST_IDLE)
        else $error("foreign address acknowledged");

    write_ack_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_11
        !start_c && !stop_c && fall_c && state_q == ST_WR && cnt_q == BYTE_BITS
        |=> sda_oe && state_q == ST_WR_ACK && pend_vld_q)
        else $error("written byte not acknowledged");

    nack_release_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_14
        !start_c && !stop_c && fall_c && state_q == ST_RD_ACK && !ack_seen_q
        |=> !sda_oe [*2])
        else $error("data line held after not-acknowledge");

    commit_at_stop_a: assert property (@(posedge link_clk) // see RULE_24
        $changed(act_q) |-> $past(stop_c | link_rst))
        else $error("selection changed without stop");

    gate_follows_sel_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_15
        (downstream_clock_n_oe & ~$past(act_q)) == '0)
        else $error("deselected channel driven");

    core_follow_a: assert property (@(posedge core_clk) // see RULE_16
        $changed(chan_sel_q) |-> $past(tgl_edge | core_rst))
        else $error("core selection changed without handshake");

    reset_clears_a: assert property (@(posedge link_clk) // see RULE_17
        link_rst |=> act_q == CHAN_RST && state_q == ST_IDLE)
        else $error("reset did not clear selection");

    rd_release_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_10
        !start_c && !stop_c && fall_c && state_q == ST_RD && cnt_q == BYTE_BITS
        |=> !sda_oe && state_q == ST_RD_ACK)
        else $error("data line held into master acknowledge");

    wr_ack_hold_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_11
        state_q == ST_WR_ACK |-> sda_oe)
        else $error("write acknowledge dropped early");

    idle_quiet_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_25
        state_q == ST_IDLE |-> !sda_oe)
        else $error("idle target drives data line");

    data_gate_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_23
        (downstream_data_n_oe & ~$past(act_q)) == '0)
        else $error("deselected data channel driven");

    commit_value_a: assert property (@(posedge link_clk) disable iff (link_rst) // see RULE_26
        stop_c && pend_vld_q |=> act_q == $past(pend_q))
        else $error("stop did not commit last written byte");

    core_reset_a: assert property (@(posedge core_clk) // see RULE_18
        core_rst |=> chan_sel_q == CHAN_RST)
        else $error("core selection kept through reset");

endmodule

// ### testbench/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    // bit timing paced by the core clock
    input  wire logic clk,
    // resolved data line and driven levels
    input  wire logic sda_line,
    output logic      scl_q,
    output logic      sda_low_q
);
    localparam int QC = 25;
    initial begin
        scl_q     = 1'b1;
        sda_low_q = 1'b0;
    end
    task automatic quarter(input int n);
        repeat (n * QC) @(posedge clk);
    endtask
    task automatic start_cond();
        sda_low_q <= 1'b0;
        quarter(1);
        scl_q <= 1'b1;
        quarter(1);
        sda_low_q <= 1'b1;
        quarter(1);
        scl_q <= 1'b0;
        quarter(1);
    endtask
    task automatic stop_cond();
        sda_low_q <= 1'b1;
        quarter(1);
        scl_q <= 1'b1;
        quarter(1);
        sda_low_q <= 1'b0;
        quarter(2);
    endtask
    task automatic bit_out(input logic b);
        sda_low_q <= ~b;
        quarter(1);
        scl_q <= 1'b1;
        quarter(2);
        scl_q <= 1'b0;
        quarter(1);
    endtask
    // unstable level across the high phase comes back unknown
    task automatic bit_in(output logic b);
        logic early;
        sda_low_q <= 1'b0;
        quarter(1);
        scl_q <= 1'b1;
        quarter(1);
        early = sda_line;
        quarter(1);
        b = (early === sda_line) ? early : 1'bx;
        scl_q <= 1'b0;
        quarter(1);
    endtask
    task automatic write_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(v[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask
    task automatic read_byte(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bit_in(v[i]);
        end
        bit_out(last);
    endtask
    task automatic scl_low_hold();
        scl_q <= 1'b0;
        sda_low_q <= 1'b1;
        quarter(1);
    endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench
    import switch_pkg::*;
;
    logic        core_clk    = 1'b0;
    logic        link_clk    = 1'b1;
    logic        sys_rst     = 1'b1;
    logic        reset_pin_n = 1'b1;
    logic [2:0]  straps_q    = 3'h0;
    logic        scl;
    logic        sda_low;
    logic        sda_oe;
    logic        sda_line;
    logic [7:0]  dclk_oe;
    logic [7:0]  ddat_oe;
    logic        sda_out;
    logic [7:0]  dclk_out;
    logic [7:0]  ddat_out;
    logic [7:0]  chan_sel_q;
    logic        ack;
    logic [7:0]  v;
    int          err_count   = 0;
    int          checks_done = 0;

    always #12.5 core_clk = ~core_clk;
    always #7.5 link_clk = ~link_clk;
    assign sda_line = ~(sda_low | sda_oe);

    chan_switch DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .reset_pin_n(reset_pin_n), .addr_strap_bit0(straps_q[0]),
        .addr_strap_bit1(straps_q[1]), .addr_strap_bit2(straps_q[2]),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .downstream_clock_n_out(dclk_out), .downstream_clock_n_oe(dclk_oe),
        .downstream_data_n_out(ddat_out), .downstream_data_n_oe(ddat_oe),
        .chan_sel_q(chan_sel_q)
    );
    bus_master_model mst (.clk(core_clk), .sda_line(sda_line), .scl_q(scl), .sda_low_q(sda_low));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic addr_phase(input logic [6:0] a, input logic rw);
        mst.start_cond();
        mst.write_byte({a, rw}, ack);
    endtask
    task automatic wait_sel(input logic [7:0] exp);
        for (int i = 0; i < 40 && chan_sel_q !== exp; i++) begin
            @(posedge core_clk);
        end
        chk("chan_sel_q", exp, chan_sel_q);
    endtask

    task automatic t_defaults();
        chk("sel", CHAN_RST, chan_sel_q);
        chk("sda_oe", 8'h00, {7'h0, sda_oe});
        $display("done: defaults");
    endtask
    task automatic t_addresses();
        for (int s = 0; s < 8; s++) begin
            @(posedge core_clk);
            straps_q <= s[2:0];
            repeat (10) @(posedge core_clk);
            addr_phase(ADDR_BASE | {4'h0, s[2:0]}, 1'b0);
            mst.stop_cond();
            chk("own ack", 8'h01, {7'h0, ack});
            addr_phase(ADDR_BASE | {4'h0, s[2:0] ^ 3'h1}, 1'b0);
            mst.stop_cond();
            chk("foreign ack", 8'h00, {7'h0, ack});
        end
        straps_q <= 3'h0;
        repeat (10) @(posedge core_clk);
        $display("done: addresses");
    endtask
    task automatic t_write();
        addr_phase(ADDR_BASE, 1'b0);
        chk("wr ack", 8'h01, {7'h0, ack});
        mst.write_byte(8'h11, ack);
        chk("byte ack", 8'h01, {7'h0, ack});
        mst.write_byte(8'h4B, ack);
        chk("byte ack", 8'h01, {7'h0, ack});
        chk("sel early", CHAN_RST, chan_sel_q);
        mst.stop_cond();
        wait_sel(8'h4B);
        $display("done: write");
    endtask
    task automatic t_fanout();
        mst.scl_low_hold();
        chk("clk fanout", 8'h4B, dclk_oe);
        chk("dat fanout", 8'h4B, ddat_oe);
        chk("open drain outs", 8'h00, dclk_out | ddat_out | {7'h0, sda_out});
        mst.stop_cond();
        chk("clk idle", 8'h00, dclk_oe);
        $display("done: fanout");
    endtask
    task automatic t_read();
        addr_phase(ADDR_BASE, RW_READ);
        chk("rd ack", 8'h01, {7'h0, ack});
        mst.read_byte(1'b0, v);
        chk("rd byte", 8'h4B, v);
        mst.read_byte(1'b1, v);
        chk("rd last", 8'h4B, v);
        chk("sda free", 8'h00, {7'h0, sda_oe});
        mst.stop_cond();
        $display("done: read");
    endtask
    task automatic t_reset_pin();
        @(posedge core_clk);
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_pin_n <= 1'b1;
        wait_sel(CHAN_RST);
        mst.scl_low_hold();
        chk("clk after rst", 8'h00, dclk_oe);
        mst.stop_cond();
        $display("done: reset pin");
    endtask

    initial begin
        repeat (50000) @(posedge core_clk);
        err_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        t_defaults();
        t_addresses();
        t_write();
        t_fanout();
        t_read();
        t_reset_pin();
        tally_and_finish();
    end
endmodule
